// >>> verilog/cssep_pkg.sv
// constants shared by the composite sync separator files
// assumes a single pclk domain at 40 MHz
package cssep_pkg;
	// clocking
	localparam int PCLK_HZ = 40_000_000;
	localparam int FXX_HZ = 8_000_000;
	localparam logic [5:0] FXX_DIV = 6'(PCLK_HZ / FXX_HZ);
	localparam logic [1:0] SEL_PROHIBITED = 2'h3;
	localparam logic [1:0] SEL_DIV4 = 2'h2;
	// register byte offsets
	localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
	localparam logic [31:0] OFS_VCMP = 32'h0000_0004;
	localparam logic [31:0] OFS_HCMP = 32'h0000_0008;
	localparam logic [31:0] OFS_MASKW = 32'h0000_000C;
	localparam logic [31:0] OFS_COMP = 32'h0000_0010;
	localparam logic [31:0] OFS_COUNT = 32'h0000_0014;
	localparam logic [31:0] OFS_STAT = 32'h0000_0018;
	// control register fields
	localparam int CTRL_RUN = 7;
	localparam int CTRL_POL = 3;
	localparam int CTRL_FLAG = 2;
	localparam int CTRL_SEL_HI = 1;
	localparam int CTRL_SEL_LO = 0;
	// status register fields
	localparam int ST_VS = 0;
	localparam int ST_RAW = 1;
	localparam int ST_REP = 2;
	localparam int ST_FIRST_V = 3;
	localparam int ST_FIRST_H = 4;
	localparam int ST_MASK = 5;
	// interval counter marks
	localparam logic [7:0] HC_START = 8'h01;
	localparam logic [7:0] HC_WIDTH_END = 8'h0A;
	localparam logic [7:0] HC_FIELD_END = 8'h46;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [7:0] ONE8 = 8'h01;
	// start-up sequence
	typedef enum logic [1:0] {
		CSSEP_STOP = 2'b00,
		CSSEP_WAIT_V = 2'b01,
		CSSEP_WAIT_H = 2'b10,
		CSSEP_RUN = 2'b11
	} cssep_state_t;
endpackage

// >>> verilog/cssep_tick.sv
// separator clock edge generator: pulses for its falling and rising edges
// assumes pclk is the base clock source, one pulse per edge
module cssep_tick (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic run,
	input wire logic [1:0] clk_sel,
	// separator clock edges
	output logic fall_tick,
	output logic rise_tick
);
	logic [5:0] div_ff;
	logic [1:0] shift;
	logic [5:0] period;
	logic [5:0] last;

	// the prohibited code falls back to the slowest rate
	assign shift = (clk_sel == cssep_pkg::SEL_PROHIBITED) ?
		cssep_pkg::SEL_DIV4 : clk_sel;
	assign period = 6'(cssep_pkg::FXX_DIV << shift);
	assign last = 6'(period - 6'h01);
	assign rise_tick = run && (div_ff == last);
	assign fall_tick = run && (div_ff == 6'(last >> 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 6'h00;
		end else if (!run || div_ff >= last) begin
			div_ff <= 6'h00;
		end else begin
			div_ff <= 6'(div_ff + 6'h01);
		end
	end
endmodule

// >>> verilog/cssep_updown.sv
// saturating 8-bit up/down sync counter
// assumes sample is stable across the rise tick that uses it
module cssep_updown (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic run,
	input wire logic rise_tick,
	input wire logic sample,
	input wire logic [7:0] limit,
	// counter state
	output logic [7:0] count,
	output logic up_step,
	output logic [7:0] count_next
);
	logic [7:0] count_ff;

	assign count = count_ff;
	assign up_step = sample && (count_ff < limit);
	always_comb begin
		count_next = count_ff;
		if (up_step) begin
			count_next = 8'(count_ff + cssep_pkg::ONE8);
		end else if (!sample && count_ff != cssep_pkg::ZERO8) begin
			count_next = 8'(count_ff - cssep_pkg::ONE8);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_ff <= 8'h00;
		end else if (!run) begin
			count_ff <= 8'h00;
		end else if (rise_tick) begin
			count_ff <= count_next;
		end
	end
endmodule

// >>> verilog/cssep_top.sv
// composite sync separator with APB register access
// assumes sync input synchronous to pclk; zero wait state slave
//
// Implementation choices: the register addresses and the APB interface to the registers.
module cssep_top (
	// apb clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// video sync
	input wire logic composite_sync_input,
	output logic vertical_sync_out,
	output logic raw_horizontal_out,
	output logic repaired_horizontal_out
);
	// registers
	logic separator_run_ff, input_polarity_invert_ff, field_parity_flag_ff;
	logic sync_clock_select_hi_ff, sync_clock_select_lo_ff;
	logic [7:0] vertical_compare_value_ff, horizontal_compare_value_ff;
	logic [7:0] mask_width_value_ff, mask_width_slave_ff;
	logic [7:0] compensation_interval_value_ff;
	logic [31:0] prdata_ff;
	// separator state
	cssep_pkg::cssep_state_t state_ff, nxt_state;
	logic sample_ff, real_cause_ff, repaired_seen_ff, field_ff;
	logic vsync_ff, nxt_vsync, mask_ff, nxt_mask;
	logic raw_ff, nxt_raw, comp_ff, nxt_comp;
	logic repaired_ff, nxt_repaired;
	logic [7:0] hcnt_ff, hinc;
	// wires
	logic fall_tick, rise_tick, up_step, h_match, h_live;
	logic [7:0] sync_updown_counter, count_next;
	logic real_restart, comp_restart, restart, step, vs_rise, rep_rise;
	logic wr, rd_setup, hit, run_start;
	logic [31:0] rd_mux;

	cssep_tick u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.run(separator_run_ff),
		.clk_sel({sync_clock_select_hi_ff, sync_clock_select_lo_ff}),
		.fall_tick(fall_tick),
		.rise_tick(rise_tick)
	);

	cssep_updown u_updown (
		.pclk(pclk),
		.presetn(presetn),
		.run(separator_run_ff),
		.rise_tick(rise_tick),
		.sample(sample_ff),
		.limit(vertical_compare_value_ff),
		.count(sync_updown_counter),
		.up_step(up_step),
		.count_next(count_next)
	);

	// apb decode; the slave never waits
	assign pready = 1'b1;
	assign wr = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign pslverr = psel && penable && !hit;
	assign prdata = prdata_ff;
	assign run_start = wr && (paddr == cssep_pkg::OFS_CTRL) &&
		pwdata[cssep_pkg::CTRL_RUN] && !separator_run_ff;

	always_comb begin
		rd_mux = 32'h0000_0000;
		hit = 1'b1;
		case (paddr)
		cssep_pkg::OFS_CTRL: begin
			rd_mux[cssep_pkg::CTRL_RUN] = separator_run_ff;
			rd_mux[cssep_pkg::CTRL_POL] = input_polarity_invert_ff;
			rd_mux[cssep_pkg::CTRL_FLAG] = field_parity_flag_ff;
			rd_mux[cssep_pkg::CTRL_SEL_HI] = sync_clock_select_hi_ff;
			rd_mux[cssep_pkg::CTRL_SEL_LO] = sync_clock_select_lo_ff;
		end
		cssep_pkg::OFS_VCMP: rd_mux[7:0] = vertical_compare_value_ff;
		cssep_pkg::OFS_HCMP: rd_mux[7:0] = horizontal_compare_value_ff;
		cssep_pkg::OFS_MASKW: rd_mux[7:0] = mask_width_value_ff;
		cssep_pkg::OFS_COMP: rd_mux[7:0] = compensation_interval_value_ff;
		cssep_pkg::OFS_COUNT: rd_mux[7:0] = sync_updown_counter;
		cssep_pkg::OFS_STAT: begin
			rd_mux[cssep_pkg::ST_VS] = vsync_ff;
			rd_mux[cssep_pkg::ST_RAW] = raw_ff;
			rd_mux[cssep_pkg::ST_REP] = repaired_ff;
			rd_mux[cssep_pkg::ST_FIRST_V] = state_ff[1];
			rd_mux[cssep_pkg::ST_FIRST_H] =
				(state_ff == cssep_pkg::CSSEP_RUN);
			rd_mux[cssep_pkg::ST_MASK] = mask_ff;
		end
		default: hit = 1'b0;
		endcase
	end

	// read data captured in setup so it is a flop during access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_ff <= rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			separator_run_ff <= 1'b0;
			input_polarity_invert_ff <= 1'b0;
			sync_clock_select_hi_ff <= 1'b0;
			sync_clock_select_lo_ff <= 1'b0;
		end else if (wr && paddr == cssep_pkg::OFS_CTRL) begin
			separator_run_ff <= pwdata[cssep_pkg::CTRL_RUN];
			input_polarity_invert_ff <= pwdata[cssep_pkg::CTRL_POL];
			sync_clock_select_hi_ff <= pwdata[cssep_pkg::CTRL_SEL_HI];
			sync_clock_select_lo_ff <= pwdata[cssep_pkg::CTRL_SEL_LO];
		end
	end

	// compare values; rewriting them while running is not guarded
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vertical_compare_value_ff <= 8'h00;
			horizontal_compare_value_ff <= 8'h00;
			mask_width_value_ff <= 8'h00;
			compensation_interval_value_ff <= 8'h00;
		end else if (wr) begin
			if (paddr == cssep_pkg::OFS_VCMP) begin
				vertical_compare_value_ff <= pwdata[7:0];
			end
			if (paddr == cssep_pkg::OFS_HCMP) begin
				horizontal_compare_value_ff <= pwdata[7:0];
			end
			if (paddr == cssep_pkg::OFS_MASKW) begin
				mask_width_value_ff <= pwdata[7:0];
			end
			if (paddr == cssep_pkg::OFS_COMP) begin
				compensation_interval_value_ff <= pwdata[7:0];
			end
		end
	end

	// mask width slave copy: on run start and each later repaired pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_width_slave_ff <= 8'h00;
		end else if (run_start || (rep_rise && repaired_seen_ff)) begin
			mask_width_slave_ff <= mask_width_value_ff;
		end
	end

	// input sampled on the separator clock falling edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_ff <= 1'b0;
		end else if (fall_tick) begin
			sample_ff <= composite_sync_input ^
				input_polarity_invert_ff;
		end
	end

	// vertical sync: set at the limit, cleared back at zero
	always_comb begin
		nxt_vsync = vsync_ff;
		if (!separator_run_ff) begin
			nxt_vsync = 1'b0;
		end else if (sync_updown_counter == vertical_compare_value_ff) begin
			nxt_vsync = 1'b1;
		end else if (sync_updown_counter == cssep_pkg::ZERO8) begin
			nxt_vsync = 1'b0;
		end
	end
	assign vs_rise = nxt_vsync && !vsync_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vsync_ff <= 1'b0;
		end else begin
			vsync_ff <= nxt_vsync;
		end
	end

	// horizontal match only on an upward step
	assign h_match = rise_tick && up_step &&
		(count_next == horizontal_compare_value_ff);

	// start-up sequence
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
		cssep_pkg::CSSEP_STOP: begin
			if (separator_run_ff) begin
				nxt_state = cssep_pkg::CSSEP_WAIT_V;
			end
		end
		cssep_pkg::CSSEP_WAIT_V: begin
			if (vs_rise) begin
				nxt_state = cssep_pkg::CSSEP_WAIT_H;
			end
		end
		cssep_pkg::CSSEP_WAIT_H: begin
			if (h_match) begin
				nxt_state = cssep_pkg::CSSEP_RUN;
			end
		end
		cssep_pkg::CSSEP_RUN: nxt_state = cssep_pkg::CSSEP_RUN;
		default: nxt_state = cssep_pkg::CSSEP_STOP;
		endcase
		if (!separator_run_ff) begin
			nxt_state = cssep_pkg::CSSEP_STOP;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= cssep_pkg::CSSEP_STOP;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// interval counter control
	assign h_live = (state_ff == cssep_pkg::CSSEP_RUN) && separator_run_ff;
	assign real_restart = h_match && !mask_ff &&
		(h_live || state_ff == cssep_pkg::CSSEP_WAIT_H);
	assign comp_restart = h_live && rise_tick && !real_restart &&
		(hcnt_ff == compensation_interval_value_ff);
	assign restart = real_restart || comp_restart;
	assign step = h_live && rise_tick && !restart;
	assign hinc = 8'(hcnt_ff + cssep_pkg::ONE8);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hcnt_ff <= 8'h00;
		end else if (!separator_run_ff || restart) begin
			hcnt_ff <= 8'h00;
		end else if (step) begin
			hcnt_ff <= hinc;
		end
	end

	// remembers whether the running interval began on a real pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			real_cause_ff <= 1'b0;
		end else if (real_restart) begin
			real_cause_ff <= 1'b1;
		end else if (comp_restart || !separator_run_ff) begin
			real_cause_ff <= 1'b0;
		end
	end

	// mask, raw and compensation pulses
	always_comb begin
		nxt_mask = mask_ff;
		nxt_raw = raw_ff;
		nxt_comp = comp_ff;
		if (step && hinc == cssep_pkg::HC_START) begin
			nxt_mask = 1'b1;
			nxt_raw = real_cause_ff;
		end else if (step && hinc == mask_width_slave_ff) begin
			nxt_mask = 1'b0;
		end
		if (step && hinc == cssep_pkg::HC_WIDTH_END) begin
			nxt_raw = 1'b0;
			nxt_comp = 1'b0;
		end
		if (comp_restart) begin
			nxt_comp = 1'b1;
		end
		if (!h_live) begin
			nxt_mask = 1'b0;
			nxt_raw = 1'b0;
			nxt_comp = 1'b0;
		end
		nxt_repaired = nxt_raw || nxt_comp;
	end
	assign rep_rise = nxt_repaired && !repaired_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_ff <= 1'b0;
			raw_ff <= 1'b0;
			comp_ff <= 1'b0;
			repaired_ff <= 1'b0;
		end else begin
			mask_ff <= nxt_mask;
			raw_ff <= nxt_raw;
			comp_ff <= nxt_comp;
			repaired_ff <= nxt_repaired;
		end
	end

	// first repaired pulse after start does not reload the mask width
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			repaired_seen_ff <= 1'b0;
		end else if (!separator_run_ff) begin
			repaired_seen_ff <= 1'b0;
		end else if (rep_rise) begin
			repaired_seen_ff <= 1'b1;
		end
	end

	// field discrimination flip-flop; the set wins a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			field_ff <= 1'b0;
		end else if (!separator_run_ff) begin
			field_ff <= 1'b0;
		end else if (rep_rise) begin
			field_ff <= 1'b1;
		end else if (step && hinc == cssep_pkg::HC_FIELD_END) begin
			field_ff <= 1'b0;
		end
	end

	// flag only latched once a first vertical pulse is behind us
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			field_parity_flag_ff <= 1'b0;
		end else if (vs_rise && state_ff[1]) begin
			field_parity_flag_ff <= field_ff;
		end
	end

	assign vertical_sync_out = vsync_ff;
	assign raw_horizontal_out = raw_ff;
	assign repaired_horizontal_out = repaired_ff;
endmodule

// >>> tb/cssep_chk.sv
// checker: port relations of the composite sync separator
// assumes ctrl and vertical compare change only through apb writes
module cssep_chk (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// video sync
	input wire logic composite_sync_input,
	input wire logic vertical_sync_out,
	input wire logic raw_horizontal_out,
	input wire logic repaired_horizontal_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ctrl_ff;
	logic [7:0] vcmp_ff;
	logic [15:0] hi_ff;
	logic [15:0] lo_ff;
	logic [15:0] rawlen_ff;
	wire logic run = ctrl_ff[cssep_pkg::CTRL_RUN];
	wire logic eff = composite_sync_input ^ ctrl_ff[cssep_pkg::CTRL_POL];
	// select 11 acts as 10
	wire logic [15:0] per = (ctrl_ff[1:0] == 2'h0) ? 16'h0005 :
		(ctrl_ff[1:0] == 2'h1) ? 16'h000A : 16'h0014;
	// two periods of slack cover tick phase at run start
	wire logic [15:0] lim = ({8'h00, vcmp_ff} + 16'h0002) * per;
	wire logic unmapped = (paddr > cssep_pkg::OFS_STAT) ||
		(paddr[1:0] != 2'h0);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= 8'h00;
			vcmp_ff <= 8'h00;
		end else if (psel && penable && pwrite) begin
			if (paddr == cssep_pkg::OFS_CTRL) ctrl_ff <= pwdata[7:0];
			if (paddr == cssep_pkg::OFS_VCMP) vcmp_ff <= pwdata[7:0];
		end
	end
	// saturating run lengths of the effective input level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) hi_ff <= 16'h0000;
		else if (!run || !eff) hi_ff <= 16'h0000;
		else if (hi_ff != 16'hFFFF) hi_ff <= hi_ff + 16'h0001;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) lo_ff <= 16'h0000;
		else if (!run || eff) lo_ff <= 16'h0000;
		else if (lo_ff != 16'hFFFF) lo_ff <= lo_ff + 16'h0001;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) rawlen_ff <= 16'h0000;
		else if (!raw_horizontal_out) rawlen_ff <= 16'h0000;
		else rawlen_ff <= rawlen_ff + 16'h0001;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rep_or;
		raw_horizontal_out |-> repaired_horizontal_out;
	endproperty
	a_rep_or: assert property (p_rep_or)
		else $error("repaired misses raw");
	property p_raw_width;
		$fell(raw_horizontal_out) && run |-> rawlen_ff == 16'h0009 * per;
	endproperty
	a_raw_width: assert property (p_raw_width)
		else $error("raw width");
	property p_stop;
		!run |=> !vertical_sync_out && !raw_horizontal_out &&
			!repaired_horizontal_out;
	endproperty
	a_stop: assert property (p_stop)
		else $error("output while stopped");
	property p_vs_on;
		run && vcmp_ff != 8'h00 && hi_ff == lim |-> vertical_sync_out;
	endproperty
	a_vs_on: assert property (p_vs_on)
		else $error("vertical not set");
	property p_vs_off;
		run && vcmp_ff != 8'h00 && lo_ff == lim |-> !vertical_sync_out;
	endproperty
	a_vs_off: assert property (p_vs_off)
		else $error("vertical not clear");
	property p_raw_src;
		$rose(raw_horizontal_out) |-> lo_ff <= 16'h0002 * per + 16'h0002;
	endproperty
	a_raw_src: assert property (p_raw_src)
		else $error("raw without input");
	property p_err;
		psel && penable |-> pslverr == unmapped;
	endproperty
	a_err: assert property (p_err) else $error("slave error wrong");
	property p_ready;
		psel && penable |-> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("ready low in access");
	property p_rd_hi;
		psel && penable && !pwrite |-> prdata[31:8] == 24'h000000;
	endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("read upper bits");
	c_vs: cover property ($rose(vertical_sync_out));
	c_raw: cover property ($rose(raw_horizontal_out));
	c_comp: cover property ($rose(repaired_horizontal_out) &&
		!raw_horizontal_out);
endmodule

bind cssep_top cssep_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.composite_sync_input(composite_sync_input),
	.vertical_sync_out(vertical_sync_out),
	.raw_horizontal_out(raw_horizontal_out),
	.repaired_horizontal_out(repaired_horizontal_out));

// >>> tb/cssep_src.sv
// composite sync source model driving the separator input
// assumes one bench process calls its tasks
module cssep_src (
	// clock
	input wire logic pclk,
	// sync line
	output logic composite_sync_input
);
	timeunit 1ns;
	timeprecision 1ps;
	initial composite_sync_input = 1'b0;
	// a level for n pclk cycles, changed just after a rising edge
	task automatic hold(input logic lvl, input int n);
		@(posedge pclk);
		composite_sync_input <= lvl;
		repeat (n - 1) @(posedge pclk);
	endtask
	// one line in fsync periods of p; the dip is noise inside the tip
	task automatic line(input int p);
		hold(1'b1, 3 * p);
		hold(1'b0, 2 * p);
		hold(1'b1, 5 * p);
		hold(1'b0, 30 * p);
	endtask
endmodule

// >>> tb/tb_composite_sync_separator.sv
// bench for the composite sync separator
// assumes zero wait state apb slave, base separator clock pclk/5
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
	n_fail++; $display("Error %s exp %0h got %0h", nm, ex, got); end end
module tb_composite_sync_separator;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0000_0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rq;
	logic pready, pslverr, re, csync, vs, raw, rep, raw_q, rep_q;
	int checks = 0;
	int n_fail = 0;
	int cyc = 0;
	int raw_n = 0;
	int comp_n = 0;
	int raw_len = 0;
	int raw_w = 0;
	cssep_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.composite_sync_input(csync), .vertical_sync_out(vs),
		.raw_horizontal_out(raw), .repaired_horizontal_out(rep));
	cssep_src src_u (.pclk(pclk), .composite_sync_input(csync));
	always #12.5 pclk = ~pclk;
	// pulse counts and last raw width, from pre-edge values
	always @(posedge pclk) begin
		raw_q <= raw;
		rep_q <= rep;
		if (raw === 1'b1 && raw_q === 1'b0) raw_n++;
		if (rep === 1'b1 && rep_q === 1'b0 && raw !== 1'b1) comp_n++;
		if (raw === 1'b0 && raw_q === 1'b1) raw_w = raw_len;
		raw_len = (raw === 1'b1) ? raw_len + 1 : 0;
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task automatic apb(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic t_regs();
		apb(1'b0, cssep_pkg::OFS_CTRL, 32'h0000_0000);
		`CHK("ctrl reset", 32'h0000_0000, rq)
		apb(1'b0, 32'h0000_0040, 32'h0000_0000);
		`CHK("unmapped data", 32'h0000_0000, rq)
		`CHK("unmapped err", 1'b1, re)
	endtask
	task automatic t_sep(input logic [1:0] sel);
		int p, r0, c0;
		p = 5 << sel;
		do_reset();
		apb(1'b1, cssep_pkg::OFS_VCMP, 32'h0000_0020);
		apb(1'b1, cssep_pkg::OFS_HCMP, 32'h0000_0002);
		apb(1'b1, cssep_pkg::OFS_MASKW, 32'h0000_000C);
		apb(1'b1, cssep_pkg::OFS_COMP, 32'h0000_0030);
		apb(1'b1, cssep_pkg::OFS_CTRL, {24'h000000, 6'h20, sel});
		r0 = raw_n;
		repeat (2) src_u.line(p);
		`CHK("raw before vertical", r0, raw_n)
		src_u.hold(1'b1, 40 * p);
		apb(1'b0, cssep_pkg::OFS_COUNT, 32'h0000_0000);
		`CHK("count ceiling", 32'h0000_0020, rq)
		`CHK("vertical set", 1'b1, vs)
		src_u.hold(1'b0, 40 * p);
		apb(1'b0, cssep_pkg::OFS_COUNT, 32'h0000_0000);
		`CHK("count floor", 32'h0000_0000, rq)
		`CHK("vertical clear", 1'b0, vs)
		`CHK("raw on down count", r0, raw_n)
		src_u.line(p);
		r0 = raw_n;
		repeat (3) src_u.line(p);
		`CHK("raw pulses", r0 + 3, raw_n)
		`CHK("raw width", 9 * p, raw_w)
		apb(1'b0, cssep_pkg::OFS_STAT, 32'h0000_0000);
		`CHK("first flags", 2'b11, rq[4:3])
		r0 = raw_n;
		c0 = comp_n;
		// interval near 38 at line end, so matches near 10p and 58p
		src_u.hold(1'b0, 80 * p);
		`CHK("compensations", c0 + 2, comp_n)
		`CHK("raw in gap", r0, raw_n)
		// second vertical; field ff still set by the repaired pulses
		src_u.hold(1'b1, 40 * p);
		apb(1'b0, cssep_pkg::OFS_CTRL, 32'h0000_0000);
		`CHK("field flag", 1'b1, rq[cssep_pkg::CTRL_FLAG])
	endtask
	task automatic t_pol();
		do_reset();
		apb(1'b1, cssep_pkg::OFS_VCMP, 32'h0000_0004);
		apb(1'b1, cssep_pkg::OFS_CTRL, 32'h0000_0089);
		src_u.hold(1'b0, 100);
		`CHK("inverted vertical", 1'b1, vs)
		apb(1'b1, cssep_pkg::OFS_CTRL, 32'h0000_0008);
		apb(1'b0, cssep_pkg::OFS_COUNT, 32'h0000_0000);
		`CHK("stopped count", 32'h0000_0000, rq)
		`CHK("stopped vertical", 1'b0, vs)
	endtask
	initial begin
		do_reset();
		t_regs();
		for (int s = 0; s < 3; s++)
			t_sep(2'(s));
		t_pol();
		complete_run();
	end
endmodule
